// ===== include/dds_map.vh
`ifndef DDS_MAP_VH
`define DDS_MAP_VH

// register byte addresses
`define A_STEP_LO  6'h00
`define A_STEP_HI  6'h04
`define A_PHASE    6'h08
`define A_CTRL     6'h0C
`define A_MRATE    6'h10
`define A_DEV      6'h14
`define A_IDX      6'h18
`define A_AMPL     6'h1C
`define A_BCNT     6'h20
`define A_MADDR    6'h24
`define A_MDATA    6'h28
`define A_TRIG     6'h2C
`define A_STAT     6'h30
`define A_ACC      6'h34

// widths
`define ACC_W      48
`define WAVE_AW    12
`define SAMP_W     12
`define MMEM_AW    8

// control field positions
`define C_MOD_EN   0
`define C_TYPE_LO  1
`define C_TYPE_HI  3
`define C_FUNC_LO  4
`define C_FUNC_HI  6
`define C_AM_EXT   7
`define CTRL_W     8

// modulation types
`define MT_AM      3'h0
`define MT_FM      3'h1
`define MT_PM      3'h2
`define MT_BURST   3'h3
`define MT_SWEEP   3'h4

// output functions
`define FN_SINE    3'h0
`define FN_SQUARE  3'h1
`define FN_TRI     3'h2
`define FN_RAMP    3'h3
`define FN_ARB     3'h4

// reset values
`define RST_STEP   48'h0000_0000_0000
`define RST_CTRL   8'h00
`define RST_AMPL   12'hFFF
`define RST_BCNT   16'h0001

`endif

// ===== logic/dds_phase_accumulator.v
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "dds_map.vh"

module dds_phase_accumulator (
   input  wire                 clock,
   input  wire                 rst,
   input  wire [5:0]           addr,
   input  wire [31:0]          wdata,
   input  wire                 wr,
   input  wire                 rd,
   output reg  [31:0]          rdata,
   output reg  [`WAVE_AW-1:0]  wave_addr,
   input  wire [`SAMP_W-1:0]   wave_data,
   output reg  [`SAMP_W-1:0]   dac_data,
   output reg  [`SAMP_W-1:0]   amp_ctl,
   output wire                 am_ext_sel,
   output wire                 sine_path_sel,
   output wire                 fast_path_sel,
   output wire                 square_sel,
   input  wire                 cmp_in,
   output wire                 sync_out,
   output wire                 burst_active
);

   localparam S_IDLE = 1'b0;
   localparam S_RUN  = 1'b1;

   // programmed parameters
   reg  [`ACC_W-1:0]   step_q;
   reg  [31:0]         step_lo_q;
   reg  [`WAVE_AW-1:0] phase_q;
   reg  [`CTRL_W-1:0]  ctrl_q;
   reg  [31:0]         mrate_q;
   reg  [31:0]         dev_q;
   reg  [11:0]         idx_q;
   reg  [`SAMP_W-1:0]  ampl_q;
   reg  [15:0]         bcnt_q;
   reg  [`MMEM_AW-1:0] maddr_q;

   // running state
   reg  [`ACC_W-1:0]   acc_q;
   reg  [31:0]         mph_q;
   reg  [`SAMP_W-1:0]  msamp_q;
   reg                 state_q;
   reg  [15:0]         cycles_q;
   reg                 trig_q;
   reg                 cmp_s1_q;
   reg                 cmp_s2_q;

   // modulation memory
   reg  [`SAMP_W-1:0]  mmem [0:(1<<`MMEM_AW)-1];

   wire [2:0] mtype   = ctrl_q[`C_TYPE_HI:`C_TYPE_LO];
   wire [2:0] func    = ctrl_q[`C_FUNC_HI:`C_FUNC_LO];
   wire       mod_en  = ctrl_q[`C_MOD_EN];
   wire       is_am   = mod_en && (mtype == `MT_AM);
   wire       is_fm   = mod_en && (mtype == `MT_FM);
   wire       is_pm   = mod_en && (mtype == `MT_PM);
   wire       is_bst  = mod_en && (mtype == `MT_BURST);
   wire       is_swp  = mod_en && (mtype == `MT_SWEEP);

   // signed sample scaled by the modulation index
   wire signed [24:0] idx_prod;
   wire        [11:0] scaled;
   assign idx_prod = $signed(msamp_q) * $signed({1'b0, idx_q});
   assign scaled   = idx_prod[22:11];

   // frequency deviation terms
   wire signed [44:0] fm_prod;
   wire        [43:0] swp_prod;
   assign fm_prod  = $signed(msamp_q) * $signed({1'b0, dev_q});
   assign swp_prod = mph_q[31:20] * dev_q;

   // effective step after frequency modulation or sweep
   reg  [`ACC_W-1:0] step_eff;
   always @* begin
      step_eff = step_q;
      if (is_fm) begin
         step_eff = step_q + {{3{fm_prod[44]}}, fm_prod};
      end else if (is_swp) begin
         step_eff = step_q + {4'h0, swp_prod};
      end else if (is_bst && state_q == S_IDLE) begin
         step_eff = {`ACC_W{1'b0}};
      end
   end

   // full-width sum; carry marks one pass of the table
   wire [`ACC_W:0] sum;
   assign sum = {1'b0, acc_q} + {1'b0, step_eff};
   wire wrap = sum[`ACC_W];

   wire last_cycle = wrap && (cycles_q + 16'h0001 >= bcnt_q);

   // burst sequencing
   reg        state_d;
   reg [15:0] cycles_d;
   always @* begin
      state_d  = state_q;
      cycles_d = cycles_q;
      case (state_q)
         S_IDLE: begin
            cycles_d = 16'h0000;
            if (is_bst && trig_q) begin
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            if (!is_bst) begin
               state_d = S_IDLE;
            end else if (last_cycle) begin
               state_d = S_IDLE;
            end else if (wrap) begin
               cycles_d = cycles_q + 16'h0001;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // phase accumulator
   reg [`ACC_W-1:0] acc_d;
   always @* begin
      acc_d = sum[`ACC_W-1:0];
      if (is_bst && state_q == S_RUN && last_cycle) begin
         acc_d = {`ACC_W{1'b0}};
      end else if (is_bst && state_q == S_IDLE) begin
         acc_d = {`ACC_W{1'b0}};
      end
   end

   // address from top bits plus static and modulated phase
   wire [`WAVE_AW-1:0] pm_ofs = is_pm ? scaled : {`WAVE_AW{1'b0}};
   wire [`WAVE_AW-1:0] addr_d;
   assign addr_d = acc_q[`ACC_W-1 -: `WAVE_AW] + phase_q + pm_ofs;

   // amplitude modulation level in offset binary
   wire [11:0] am_lvl = {~scaled[11], scaled[10:0]};
   wire [23:0] am_prod;
   assign am_prod = ampl_q * am_lvl;

   always @(posedge clock) begin
      if (rst) begin
         acc_q    <= {`ACC_W{1'b0}};
         mph_q    <= 32'h0000_0000;
         msamp_q  <= 12'h000;
         state_q  <= S_IDLE;
         cycles_q <= 16'h0000;
      end else begin
         acc_q    <= acc_d;
         mph_q    <= mph_q + mrate_q;
         msamp_q  <= mmem[mph_q[31:32-`MMEM_AW]];
         state_q  <= state_d;
         cycles_q <= cycles_d;
      end
   end

   // sample path, one word each cycle
   always @(posedge clock) begin
      if (rst) begin
         wave_addr <= {`WAVE_AW{1'b0}};
         dac_data  <= {`SAMP_W{1'b0}};
         amp_ctl   <= `RST_AMPL;
      end else begin
         wave_addr <= addr_d;
         dac_data  <= wave_data;
         amp_ctl   <= is_am ? am_prod[23:12] : ampl_q;
      end
   end

   // comparator synchroniser
   always @(posedge clock) begin
      if (rst) begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         cmp_s1_q <= cmp_in;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   assign sync_out      = cmp_s2_q;

   // output path decode; square rides the sine path into the comparator
   reg path_sine;
   reg path_fast;
   reg path_square;
   always @* begin
      path_sine   = 1'b0;
      path_fast   = 1'b0;
      path_square = 1'b0;
      case (func)
         `FN_SINE: begin
            path_sine = 1'b1;
         end
         `FN_SQUARE: begin
            path_sine   = 1'b1;
            path_square = 1'b1;
         end
         `FN_TRI, `FN_RAMP, `FN_ARB: begin
            path_fast = 1'b1;
         end
         default: begin
         end
      endcase
   end

   assign square_sel    = path_square;
   assign sine_path_sel = path_sine;
   assign fast_path_sel = path_fast;
   assign am_ext_sel    = ctrl_q[`C_AM_EXT];
   assign burst_active  = (state_q == S_RUN);

   // modulation memory write port
   always @(posedge clock) begin
      if (wr && addr == `A_MDATA) begin
         mmem[maddr_q] <= wdata[`SAMP_W-1:0];
      end
   end

   // register writes
   always @(posedge clock) begin
      if (rst) begin
         step_q    <= `RST_STEP;
         step_lo_q <= 32'h0000_0000;
         phase_q   <= {`WAVE_AW{1'b0}};
         ctrl_q    <= `RST_CTRL;
         mrate_q   <= 32'h0000_0000;
         dev_q     <= 32'h0000_0000;
         idx_q     <= 12'h000;
         ampl_q    <= `RST_AMPL;
         bcnt_q    <= `RST_BCNT;
         maddr_q   <= {`MMEM_AW{1'b0}};
         trig_q    <= 1'b0;
      end else begin
         trig_q <= wr && (addr == `A_TRIG);
         if (wr) begin
            case (addr)
               `A_STEP_LO: begin
                  step_lo_q <= wdata;
               end
               `A_STEP_HI: begin
                  step_q <= {wdata[15:0], step_lo_q};
               end
               `A_PHASE: begin
                  phase_q <= wdata[`WAVE_AW-1:0];
               end
               `A_CTRL: begin
                  ctrl_q <= wdata[`CTRL_W-1:0];
               end
               `A_MRATE: begin
                  mrate_q <= wdata;
               end
               `A_DEV: begin
                  dev_q <= wdata;
               end
               `A_IDX: begin
                  idx_q <= wdata[11:0];
               end
               `A_AMPL: begin
                  ampl_q <= wdata[`SAMP_W-1:0];
               end
               `A_BCNT: begin
                  bcnt_q <= wdata[15:0];
               end
               `A_MADDR: begin
                  maddr_q <= wdata[`MMEM_AW-1:0];
               end
               `A_MDATA: begin
                  maddr_q <= maddr_q + {{(`MMEM_AW-1){1'b0}}, 1'b1};
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read mux, data valid only in the cycle after rd
   reg [31:0] rmux;
   always @* begin
      rmux = 32'h0000_0000;
      case (addr)
         `A_STEP_LO: begin
            rmux = step_q[31:0];
         end
         `A_STEP_HI: begin
            rmux = {16'h0000, step_q[47:32]};
         end
         `A_PHASE: begin
            rmux = {20'h00000, phase_q};
         end
         `A_CTRL: begin
            rmux = {24'h000000, ctrl_q};
         end
         `A_MRATE: begin
            rmux = mrate_q;
         end
         `A_DEV: begin
            rmux = dev_q;
         end
         `A_IDX: begin
            rmux = {20'h00000, idx_q};
         end
         `A_AMPL: begin
            rmux = {20'h00000, ampl_q};
         end
         `A_BCNT: begin
            rmux = {16'h0000, bcnt_q};
         end
         `A_MADDR: begin
            rmux = {24'h000000, maddr_q};
         end
         `A_STAT: begin
            rmux = {15'h0000, state_q, cycles_q};
         end
         `A_ACC: begin
            rmux = acc_q[47:16];
         end
         default: begin
            rmux = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clock) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rd ? rmux : 32'h0000_0000;
      end
   end

endmodule

// ===== tb/wave_mem_model.sv
`timescale 1ns/100ps
// waveform table stand-in: answers in the same cycle as the address
module wave_mem_model (
   input  wire logic [11:0] wave_addr,
   output logic      [11:0] wave_data
);
   assign wave_data = wave_addr ^ 12'h5A5;
endmodule

// ===== tb/dds_checker.sv
`timescale 1ns/100ps
`include "dds_map.vh"
module dds_checker (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [5:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [31:0] rdata,
   input  wire logic [11:0] wave_data,
   input  wire logic [11:0] dac_data,
   input  wire logic        am_ext_sel,
   input  wire logic        sine_path_sel,
   input  wire logic        fast_path_sel,
   input  wire logic        square_sel,
   input  wire logic        cmp_in,
   input  wire logic        sync_out,
   input  wire logic        burst_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire ctrl_wr = wr && addr == `A_CTRL;
   chk_dac_copy: assert property (!$past(rst) |-> dac_data == $past(wave_data))
      else $error("dac data not previous sample");
   chk_square_on_sine: assert property (square_sel |-> sine_path_sel && !fast_path_sel)
      else $error("square not on sine path");
   chk_paths_exclusive: assert property (fast_path_sel |-> !sine_path_sel)
      else $error("both paths selected");
   chk_sync_two_flop: assert property (!$past(rst) && !$past(rst, 2) |-> sync_out == $past(cmp_in, 2))
      else $error("sync out not delayed comparator");
   chk_rdata_idle: assert property (!$past(rd) && !$past(rst) |-> rdata == 32'h0)
      else $error("read data without read");
   chk_am_source: assert property (ctrl_wr |=> am_ext_sel == $past(wdata[`C_AM_EXT]))
      else $error("am source select wrong");
   chk_square_sel: assert property (ctrl_wr |=> square_sel == ($past(wdata[6:4]) == `FN_SQUARE))
      else $error("square select wrong");
   chk_fast_path: assert property (ctrl_wr |=> fast_path_sel == ($past(wdata[6:4]) inside {3'h2, 3'h3, 3'h4}))
      else $error("fast path select wrong");
   chk_burst_start: assert property ($rose(burst_active) |-> $past(wr, 2) && $past(addr, 2) == `A_TRIG)
      else $error("burst began without trigger");
endmodule
bind dds_phase_accumulator dds_checker chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .wave_data(wave_data), .dac_data(dac_data), .am_ext_sel(am_ext_sel),
   .sine_path_sel(sine_path_sel), .fast_path_sel(fast_path_sel), .square_sel(square_sel),
   .cmp_in(cmp_in), .sync_out(sync_out), .burst_active(burst_active));

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "dds_map.vh"
module tb;
   logic        clock = 0, rst = 1, wr = 0, rd = 0, cmp_in = 0;
   logic [5:0]  addr = 6'h00;
   logic [31:0] wdata = 32'h0;
   wire  [31:0] rdata;
   wire  [11:0] wave_addr, wave_data, dac_data, amp_ctl;
   wire         am_ext_sel, sine_path_sel, fast_path_sel, square_sel, sync_out, burst_active;
   int          error_cnt = 0, check_count = 0;
   always #5 clock = ~clock;
   wave_mem_model mem (.wave_addr(wave_addr), .wave_data(wave_data));
   dds_phase_accumulator DUT (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .wave_addr(wave_addr), .wave_data(wave_data), .dac_data(dac_data), .amp_ctl(amp_ctl),
      .am_ext_sel(am_ext_sel), .sine_path_sel(sine_path_sel), .fast_path_sel(fast_path_sel),
      .square_sel(square_sel), .cmp_in(cmp_in), .sync_out(sync_out), .burst_active(burst_active));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [5:0] a, input logic [31:0] exp, input string msg);
      @(posedge clock);
      addr <= a; rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, exp, msg);
   endtask
   // step high word in sixteenths of a table entry per cycle
   task automatic step_check(input logic [15:0] hi, input logic [11:0] inc, input logic [11:0] old);
      logic [11:0] prev;
      wr_reg(`A_STEP_LO, 32'h0);
      wr_reg(`A_STEP_HI, {16'h0, hi});
      #1 prev = wave_addr;
      @(posedge clock);
      #1 chk({20'h0, wave_addr - prev}, {20'h0, old}, "phase kept at step change");
      prev = wave_addr;
      repeat (6) begin
         @(posedge clock);
         #1 chk({20'h0, wave_addr - prev}, {20'h0, inc}, "address stride");
         chk({20'h0, dac_data}, {20'h0, prev ^ 12'h5A5}, "converter word");
         prev = wave_addr;
      end
   endtask
   task automatic s_selects;
      for (int f = 0; f < 5; f++) begin
         wr_reg(`A_CTRL, {24'h0, f[0], f[2:0], 4'h0});
         #1 chk({28'h0, am_ext_sel, square_sel, sine_path_sel, fast_path_sel},
            {28'h0, f[0], f == 1, f < 2, f > 1}, "output path selects");
      end
   endtask
   task automatic s_regs;
      chk({20'h0, amp_ctl}, 32'h0000_0FFF, "amplitude reset");
      wr_reg(`A_AMPL, 32'h0000_0123);
      rd_reg(`A_AMPL, 32'h0000_0123, "amplitude readback");
      #1 chk({20'h0, amp_ctl}, 32'h0000_0123, "internal amplitude");
      wr_reg(`A_DEV, 32'h1234_5678);
      rd_reg(`A_DEV, 32'h1234_5678, "deviation readback");
      rd_reg(6'h3C, 32'h0, "unmapped read");
      @(posedge clock);
      cmp_in <= 1'b1;
      @(posedge clock);
      #1 chk({31'h0, sync_out}, 32'h0, "sync waits two stages");
      repeat (2) @(posedge clock);
      #1 chk({31'h0, sync_out}, 32'h1, "sync follows comparator");
   endtask
   task automatic s_burst;
      int n;
      wr_reg(`A_BCNT, 32'h1);
      wr_reg(`A_CTRL, 32'h0000_0007);
      wr_reg(`A_TRIG, 32'h1);
      @(posedge clock);
      #1 chk({31'h0, burst_active}, 32'h1, "burst running");
      n = 0;
      while (burst_active === 1'b1 && n < 50) begin
         @(posedge clock);
         #1 n++;
      end
      chk({31'h0, burst_active}, 32'h0, "burst ended");
      chk(n, 32'h2, "burst length for one pass");
      if (n >= 50) tally_and_finish();
   endtask
   task automatic s_modulation;
      logic [11:0] prev;
      wr_reg(`A_MADDR, 32'h0);
      wr_reg(`A_MDATA, 32'h0000_0400);
      wr_reg(`A_IDX, 32'h0000_0800);
      wr_reg(`A_STEP_HI, 32'h0);
      wr_reg(`A_CTRL, 32'h0000_0005);
      @(posedge clock);
      #1 chk({20'h0, wave_addr}, 32'h0000_0400, "phase modulation offset");
      wr_reg(`A_CTRL, 32'h0000_0001);
      @(posedge clock);
      #1 chk({20'h0, amp_ctl}, 32'h0000_00DA, "internal amplitude modulation");
      wr_reg(`A_DEV, 32'h0400_0000);
      wr_reg(`A_CTRL, 32'h0000_0003);
      @(posedge clock);
      #1 prev = wave_addr;
      @(posedge clock);
      #1 chk({20'h0, wave_addr - prev}, 32'h0000_0001, "frequency modulation stride");
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      s_regs();
      step_check(16'h0010, 12'h001, 12'h000);
      step_check(16'h0030, 12'h003, 12'h001);
      step_check(16'h8000, 12'h800, 12'h003);
      s_selects();
      s_burst();
      s_modulation();
      tally_and_finish();
   end
endmodule
